// >>> include/ppr_pkg.sv
// shared constants and types of the process pid regulator
package ppr_pkg;
    localparam int CLK_MHZ = 40;
    localparam int UPDATE_US = 2000;
    localparam int UPDATE_CYCLES = UPDATE_US * CLK_MHZ;
    localparam int TICKS_PER_CS = 10000 / UPDATE_US;
    localparam int MS_PER_TICK = UPDATE_US / 1000;
    localparam int FULL_SCALE = 10000;
    localparam int GAIN_FULL = 1000;
    localparam int MIX_SHIFT = 10;
    localparam int MIX_ONE = 1 << MIX_SHIFT;
    localparam int LPF_SHIFT = 16;
    localparam int RAMP_SHIFT = 10;
    localparam int DIV_W = 32;
    localparam int SYNC_STAGES = 3;
    localparam int DI_GAIN_SWITCH = 0;
    localparam int DI_DIR_INVERT = 1;
    localparam int DI_COUNT = 2;
    localparam int MIN_TICK_CYCLES = 256;
    typedef enum logic [1:0] {
        GSW_NONE = 2'b00,
        GSW_TERMINAL = 2'b01,
        GSW_AUTO = 2'b10
    } ppr_gsw_e;
    typedef enum logic [2:0] {
        SP_DIGITAL = 3'h0,
        SP_AIN1 = 3'h1,
        SP_AIN2 = 3'h2,
        SP_AIN3 = 3'h3,
        SP_PULSE = 3'h4,
        SP_COMM = 3'h5
    } ppr_sp_src_e;
    typedef enum logic [3:0] {
        FB_AIN1 = 4'h0,
        FB_AIN2 = 4'h1,
        FB_AIN3 = 4'h2,
        FB_DIFF = 4'h3,
        FB_PULSE = 4'h4,
        FB_COMM = 4'h5,
        FB_SUM = 4'h6,
        FB_MAXABS = 4'h7,
        FB_MINABS = 4'h8
    } ppr_fb_src_e;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RAMP = 3'b001,
        ST_FB = 3'b010,
        ST_MIX = 3'b011,
        ST_INT = 3'b100,
        ST_OUT = 3'b101,
        ST_FIN = 3'b110
    } ppr_state_e;
    typedef logic signed [17:0] ppr_pct_t;
endpackage

// >>> include/ppr_div_if.sv
// handshake between the regulator sequencer and the shared divider
`timescale 1ns/1ps
`default_nettype none
interface ppr_div_if #(parameter int W = 32);
    logic start;
    logic done;
    logic [W-1:0] num;
    logic [W-1:0] den;
    logic [W-1:0] quot;
    modport mst (output start, output num, output den, input done, input quot);
    modport slv (input start, input num, input den, output done, output quot);
endinterface // ppr_div_if
`default_nettype wire

// >>> logic/ppr_div.sv
// iterative restoring unsigned divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module ppr_div #(
    parameter int W = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request and answer
    ppr_div_if.slv dv
);
    import ppr_pkg::*;
    localparam int CW = $clog2(W + 1);
    typedef struct packed {
        logic busy;
        logic done;
        logic [CW-1:0] cnt;
        logic [W-1:0] rem;
        logic [W-1:0] q;
        logic [W-1:0] den;
    } ppr_div_s;
    ppr_div_s r_q, r_d;
    if (W < 2 || W != $bits(dv.num)) begin : g_chk
        $error("ppr_div: width mismatch");
    end
    always_comb begin
        logic [W:0] t;
        t = {r_q.rem, r_q.q[W-1]};
        r_d = r_q;
        r_d.done = 1'b0;
        if (r_q.busy) begin
            r_d.q = {r_q.q[W-2:0], 1'b0};
            if (t >= {1'b0, r_q.den}) begin
                t = t - {1'b0, r_q.den};
                r_d.q[0] = 1'b1;
            end
            r_d.rem = t[W-1:0];
            r_d.cnt = r_q.cnt - CW'(1);
            if (r_q.cnt == CW'(1)) begin
                r_d.busy = 1'b0;
                r_d.done = 1'b1;
            end
        end else if (dv.start) begin
            r_d.busy = 1'b1;
            r_d.cnt = CW'(W);
            r_d.rem = '0;
            r_d.q = dv.num;
            r_d.den = dv.den;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end
    assign dv.done = r_q.done;
    assign dv.quot = r_q.q;
endmodule // ppr_div
`default_nettype wire

// >>> logic/ppr_lpf.sv
// first-order low-pass stage, y moves by (x - y) * k / 2^16 per load
`timescale 1ns/1ps
`default_nettype none
module ppr_lpf (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // sample in
    input wire logic load,
    input wire logic [16:0] k,
    input wire ppr_pkg::ppr_pct_t x,
    // filtered value
    output ppr_pkg::ppr_pct_t y
);
    import ppr_pkg::*;
    typedef struct packed {
        ppr_pct_t y;
    } ppr_lpf_s;
    ppr_lpf_s r_q, r_d;
    always_comb begin
        logic signed [37:0] p;
        p = 38'(signed'({x[17], x}) - signed'({r_q.y[17], r_q.y})) * signed'({1'b0, k});
        r_d = r_q;
        // k of 2^16 makes y follow x exactly, so a zero time constant needs no bypass
        if (load) begin
            r_d.y = r_q.y + 18'(p >>> LPF_SHIFT);
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end
    assign y = r_q.y;
endmodule // ppr_lpf
`default_nettype wire

// >>> logic/ppr_regulator.sv
// process pid regulator: source selection, two gain sets, limits, filters
// Function
// - setting source 0 digital value, 1-3 analog inputs, 4 pulse, 5 communication.
// - feedback source 0-8: analog, difference, pulse, comm, sum, larger or smaller magnitude.
// - setting and feedback are 0..100% relative; output drives feedback toward setting.
// - displays scale setting and feedback so 100% reads the display full scale.
// - proportional gain 100.0 at full deviation gives maximum frequency correction.
// - full deviation held one integral time integrates to maximum frequency.
// - full feedback change within differential time gives maximum frequency; zero disables.
// - second gain set with identical scaling and ranges.
// - terminal function 28 off selects set one, on selects set two.
// - automatic: set one below threshold one, set two above two, interpolated between.
// - on start the output holds the initial value for the hold time.
// - reverse output frequency magnitude capped at cut-off, itself bounded by maximum.
// - absolute deviation below deadband suspends regulation, output holds.
// - differential contribution clamped to the configured range.
// - selected feedback low-pass filtered; zero time means no filtering.
// - output frequency low-pass filtered; zero time means no filtering.
// - direction 0 raises output when feedback is low, 1 lowers; terminal inverts.
`timescale 1ns/1ps
`default_nettype none
module ppr_regulator #(
    parameter int TICK_CYCLES = ppr_pkg::UPDATE_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // drive state and terminal functions
    input wire logic run,
    input wire logic [1:0] digital_input_terminal,
    // setting and feedback sources, 0.01 % units
    input wire logic signed [15:0] analog_input_one,
    input wire logic signed [15:0] analog_input_two,
    input wire logic signed [15:0] analog_input_three,
    input wire logic [15:0] pulse_input,
    input wire logic signed [15:0] comm_value,
    // source and display configuration
    input wire ppr_pkg::ppr_sp_src_e setting_source_select,
    input wire logic [15:0] digital_setpoint,
    input wire ppr_pkg::ppr_fb_src_e feedback_source_select,
    input wire logic [15:0] display_full_scale,
    // gain sets: gain 0.1, integral 0.01 s, differential 1 ms units
    input wire logic [9:0] prop_gain_set_one,
    input wire logic [9:0] integral_time_set_one,
    input wire logic [13:0] diff_time_set_one,
    input wire logic [9:0] prop_gain_set_two,
    input wire logic [9:0] integral_time_set_two,
    input wire logic [13:0] diff_time_set_two,
    input wire ppr_pkg::ppr_gsw_e gain_switch_condition,
    input wire logic [15:0] switch_threshold_low,
    input wire logic [15:0] switch_threshold_high,
    // start, limits and filters
    input wire logic [15:0] start_output_value,
    input wire logic [15:0] start_hold_time,
    input wire logic [15:0] max_step_up,
    input wire logic [15:0] max_step_down,
    input wire logic [15:0] reverse_freq_cap,
    input wire logic [15:0] max_frequency,
    input wire logic [15:0] deviation_deadband,
    input wire logic [15:0] diff_term_clamp,
    input wire logic [15:0] setpoint_ramp_time,
    input wire logic [12:0] feedback_filter_time,
    input wire logic [12:0] output_filter_time,
    input wire logic action_direction,
    // results
    output logic signed [17:0] freq_reference,
    output logic freq_valid,
    output ppr_pkg::ppr_pct_t regulator_output,
    output logic [15:0] setpoint_display,
    output logic [15:0] feedback_display
);
    import ppr_pkg::*;

    typedef struct packed {
        ppr_state_e st;
        logic issued;
        logic [19:0] tcnt;
        logic [DI_COUNT*SYNC_STAGES-1:0] sy;
        logic [DI_COUNT-1:0] di;
        logic run_q;
        logic [19:0] hold;
        logic [23:0] sp_fine;
        ppr_pct_t fb_raw;
        ppr_pct_t fb_prev;
        logic [10:0] w;
        logic signed [27:0] acc;
        ppr_pct_t pid;
        logic signed [17:0] freq;
        logic valid;
        logic [15:0] sp_disp;
        logic [15:0] fb_disp;
    } ppr_reg_s;

    ppr_reg_s r_q, r_d;
    ppr_div_if #(.W(DIV_W)) dv ();
    ppr_pct_t fb_filt;
    ppr_pct_t out_filt;
    logic fb_load;
    logic out_load;

    if (TICK_CYCLES < MIN_TICK_CYCLES || TICK_CYCLES >= (1 << 20)) begin : g_chk
        $error("ppr_regulator: TICK_CYCLES out of range");
    end

    function automatic int sat(input int v, input int lo, input int hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic int iabs(input int v);
        return (v < 0) ? -v : v;
    endfunction

    function automatic int mix(input int a, input int b, input int w);
        return a + (((b - a) * w) >>> MIX_SHIFT);
    endfunction

    ppr_div #(.W(DIV_W)) u_div (
        .clk(clk),
        .rst_n(rst_n),
        .dv(dv)
    );

    ppr_lpf u_fb_lpf (
        .clk(clk),
        .rst_n(rst_n),
        .load(fb_load),
        .k(dv.quot[16:0]),
        .x(r_q.fb_raw),
        .y(fb_filt)
    );

    ppr_lpf u_out_lpf (
        .clk(clk),
        .rst_n(rst_n),
        .load(out_load),
        .k(dv.quot[16:0]),
        .x(r_q.pid),
        .y(out_filt)
    );

    assign fb_load = (r_q.st == ST_FB) && dv.done;
    assign out_load = (r_q.st == ST_OUT) && dv.done;

    always_comb begin
        int a1;
        int a2;
        int spt;
        int fbs;
        int sp;
        int e;
        int ae;
        int lo;
        int hi;
        int w;
        int kp;
        int ti;
        int td;
        int lim;
        int acn;
        int pe;
        int ie;
        int de;
        int u;
        int f;
        int cap;
        int tgt;
        int cur;
        int n;
        int dn;
        logic dir;
        a1 = int'(analog_input_one);
        a2 = int'(analog_input_two);
        spt = 0;
        fbs = 0;
        n = 0;
        dn = 1;
        r_d = r_q;
        r_d.valid = 1'b0;
        r_d.run_q = run;
        // a change is taken once the last two stages agree
        r_d.sy = {r_q.sy[DI_COUNT*SYNC_STAGES-DI_COUNT-1:0], digital_input_terminal};
        for (int i = 0; i < DI_COUNT; i++) begin
            if (r_q.sy[DI_COUNT+i] == r_q.sy[2*DI_COUNT+i]) begin
                r_d.di[i] = r_q.sy[DI_COUNT+i];
            end
        end
        case (setting_source_select)
            SP_AIN1: spt = a1;
            SP_AIN2: spt = a2;
            SP_AIN3: spt = int'(analog_input_three);
            SP_PULSE: spt = int'(pulse_input);
            SP_COMM: spt = int'(comm_value);
            default: spt = int'(digital_setpoint);
        endcase
        case (feedback_source_select)
            FB_AIN1: fbs = a1;
            FB_AIN2: fbs = a2;
            FB_AIN3: fbs = int'(analog_input_three);
            FB_DIFF: fbs = a1 - a2;
            FB_PULSE: fbs = int'(pulse_input);
            FB_COMM: fbs = int'(comm_value);
            FB_SUM: fbs = a1 + a2;
            FB_MAXABS: fbs = (iabs(a1) > iabs(a2)) ? iabs(a1) : iabs(a2);
            FB_MINABS: fbs = (iabs(a1) < iabs(a2)) ? iabs(a1) : iabs(a2);
            default: fbs = a1;
        endcase
        spt = sat(spt, 0, FULL_SCALE);
        fbs = sat(fbs, 0, FULL_SCALE);
        sp = int'(r_q.sp_fine >> RAMP_SHIFT);
        dir = action_direction ^ r_q.di[DI_DIR_INVERT];
        e = dir ? int'(fb_filt) - sp : sp - int'(fb_filt);
        ae = iabs(e);
        hi = int'(switch_threshold_high);
        lo = sat(int'(switch_threshold_low), 0, hi);
        case (gain_switch_condition)
            GSW_TERMINAL: w = r_q.di[DI_GAIN_SWITCH] ? MIX_ONE : 0;
            GSW_AUTO: w = int'(r_q.w);
            default: w = 0;
        endcase
        kp = mix(int'(prop_gain_set_one), int'(prop_gain_set_two), w);
        ti = mix(int'(integral_time_set_one), int'(integral_time_set_two), w);
        td = mix(int'(diff_time_set_one), int'(diff_time_set_two), w);
        ti = (ti < 1) ? 1 : ti;
        // bounding the sum bounds the integral term to full scale
        lim = FULL_SCALE * ti * TICKS_PER_CS;
        acn = sat(int'(r_q.acc) + e, -lim, lim);
        pe = kp * e / GAIN_FULL;
        de = td * (dir ? int'(fb_filt) - int'(r_q.fb_prev)
                       : int'(r_q.fb_prev) - int'(fb_filt)) / MS_PER_TICK;
        de = sat(de, -int'(diff_term_clamp), int'(diff_term_clamp));
        ie = (acn < 0) ? -int'(dv.quot) : int'(dv.quot);
        u = sat(pe + ie + de, -FULL_SCALE, FULL_SCALE);
        cap = (reverse_freq_cap > max_frequency) ? int'(max_frequency) : int'(reverse_freq_cap);
        f = int'(out_filt) * int'(max_frequency) / FULL_SCALE;
        tgt = spt << RAMP_SHIFT;
        cur = int'(r_q.sp_fine);
        case (r_q.st)
            ST_RAMP: begin
                n = FULL_SCALE << RAMP_SHIFT;
                dn = int'(setpoint_ramp_time) * TICKS_PER_CS;
            end
            ST_FB: dn = int'(feedback_filter_time) * TICKS_PER_CS + 1;
            ST_MIX: begin
                n = ((ae > lo) ? ae - lo : 0) << MIX_SHIFT;
                dn = hi - lo;
            end
            ST_INT: begin
                n = iabs(acn);
                dn = ti * TICKS_PER_CS;
            end
            ST_OUT: dn = int'(output_filter_time) * TICKS_PER_CS + 1;
            default: dn = 1;
        endcase
        if (r_q.st == ST_FB || r_q.st == ST_OUT) begin
            n = 1 << LPF_SHIFT;
        end
        dv.num = DIV_W'(n);
        dv.den = DIV_W'((dn < 1) ? 1 : dn);
        dv.start = (r_q.st != ST_IDLE) && (r_q.st != ST_FIN) && !r_q.issued;
        if (dv.start) begin
            r_d.issued = 1'b1;
        end
        if (dv.done) begin
            r_d.issued = 1'b0;
        end
        // the update timebase runs free; the sequence fits well inside one period
        r_d.tcnt = r_q.tcnt + 20'h00001;
        if (r_q.tcnt == 20'(TICK_CYCLES - 1)) begin
            r_d.tcnt = '0;
        end
        case (r_q.st)
            ST_IDLE: begin
                if (r_q.tcnt == 20'(TICK_CYCLES - 1)) begin
                    r_d.fb_raw = 18'(fbs);
                    r_d.st = ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (dv.done) begin
                    if (setpoint_ramp_time == 16'h0000) begin
                        cur = tgt;
                    end else if (cur < tgt) begin
                        cur = (cur + int'(dv.quot) > tgt) ? tgt : cur + int'(dv.quot);
                    end else begin
                        cur = (cur - int'(dv.quot) < tgt) ? tgt : cur - int'(dv.quot);
                    end
                    r_d.sp_fine = 24'(cur);
                    r_d.st = ST_FB;
                end
            end
            ST_FB: begin
                if (dv.done) begin
                    r_d.st = ST_MIX;
                end
            end
            ST_MIX: begin
                if (dv.done) begin
                    if (ae <= lo) begin
                        r_d.w = '0;
                    end else if (ae >= hi) begin
                        r_d.w = 11'(MIX_ONE);
                    end else begin
                        r_d.w = dv.quot[10:0];
                    end
                    r_d.st = ST_INT;
                end
            end
            ST_INT: begin
                if (dv.done) begin
                    r_d.fb_prev = fb_filt;
                    r_d.st = ST_OUT;
                    if (!r_q.run_q) begin
                        r_d.pid = '0;
                        r_d.acc = '0;
                    end else if (r_q.hold != 20'h00000) begin
                        r_d.pid = 18'(start_output_value);
                        r_d.acc = '0;
                        r_d.hold = r_q.hold - 20'h00001;
                    end else if (ae >= int'(deviation_deadband)) begin
                        r_d.acc = 28'(acn);
                        u = sat(u - int'(r_q.pid), -int'(max_step_down), int'(max_step_up));
                        r_d.pid = 18'(int'(r_q.pid) + u);
                    end
                end
            end
            ST_OUT: begin
                if (dv.done) begin
                    r_d.st = ST_FIN;
                end
            end
            ST_FIN: begin
                r_d.freq = 18'((f < -cap) ? -cap : f);
                r_d.valid = 1'b1;
                r_d.sp_disp = 16'(sp * int'(display_full_scale) / FULL_SCALE);
                r_d.fb_disp = 16'(sat(int'(fb_filt), 0, FULL_SCALE)
                                  * int'(display_full_scale) / FULL_SCALE);
                r_d.st = ST_IDLE;
            end
            default: r_d.st = ST_IDLE;
        endcase
        if (run && !r_q.run_q) begin
            r_d.hold = 20'(int'(start_hold_time) * TICKS_PER_CS);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign freq_reference = r_q.freq;
    assign freq_valid = r_q.valid;
    assign regulator_output = r_q.pid;
    assign setpoint_display = r_q.sp_disp;
    assign feedback_display = r_q.fb_disp;
endmodule // ppr_regulator
`default_nettype wire

// >>> verification/ppr_regulator_asserts.sv
// concurrent checks of the regulator's update cadence, limits and scaling
`timescale 1ns/1ps
`default_nettype none
module ppr_regulator_asserts #(
    parameter int TICK_CYCLES = 80000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // inputs watched
    input wire logic run,
    input wire ppr_pkg::ppr_sp_src_e setting_source_select,
    input wire logic [15:0] digital_setpoint,
    input wire logic [15:0] display_full_scale,
    input wire logic [15:0] setpoint_ramp_time,
    input wire logic [15:0] start_output_value,
    input wire logic [15:0] start_hold_time,
    input wire logic [15:0] max_step_up,
    input wire logic [15:0] max_step_down,
    input wire logic [15:0] reverse_freq_cap,
    input wire logic [15:0] max_frequency,
    input wire logic [12:0] output_filter_time,
    // outputs watched
    input wire logic signed [17:0] freq_reference,
    input wire logic freq_valid,
    input wire ppr_pkg::ppr_pct_t regulator_output,
    input wire logic [15:0] setpoint_display
);
    import ppr_pkg::*;
    int gap_q, age_q, run_age_q;
    logic seen_q, first_q;
    logic [50:0] cfg_q;
    ppr_pct_t last_q;
    logic signed [18:0] step_d;
    logic [15:0] rev_lim;
    logic [33:0] freq_exp, disp_exp;
    wire logic [50:0] cfg = {setting_source_select, digital_setpoint, display_full_scale,
        setpoint_ramp_time};
    assign step_d = regulator_output - last_q;
    assign rev_lim = (reverse_freq_cap < max_frequency) ? reverse_freq_cap : max_frequency;
    assign freq_exp = {16'h0000, regulator_output} * max_frequency / 34'd10000;
    assign disp_exp = {18'h00000, digital_setpoint} * display_full_scale / 34'd10000;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gap_q <= 0;
            age_q <= 0;
            run_age_q <= 0;
            seen_q <= 1'b0;
            first_q <= 1'b0;
            cfg_q <= cfg;
            last_q <= '0;
        end else begin
            gap_q <= freq_valid ? 1 : gap_q + 1;
            age_q <= (cfg != cfg_q) ? 0 : age_q + 1;
            cfg_q <= cfg;
            run_age_q <= run ? run_age_q + 1 : 0;
            seen_q <= seen_q | freq_valid;
            if (freq_valid)
                last_q <= regulator_output;
            if (run && run_age_q == 0)
                first_q <= 1'b1;
            else if (freq_valid && run_age_q >= TICK_CYCLES)
                first_q <= 1'b0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_strobe;
        freq_valid ##1 !freq_valid;
    endsequence
    sequence s_hold_update;
        freq_valid && first_q && run_age_q >= TICK_CYCLES && start_hold_time != 16'h0000;
    endsequence
    a_strobe_single: assert property (freq_valid |-> s_strobe)
        else $error("strobe too long");
    a_update_period: assert property (freq_valid && seen_q |-> gap_q == TICK_CYCLES)
        else $error("update period wrong");
    a_outputs_stand: assert property (!freq_valid |-> $stable(freq_reference)
        && $stable(setpoint_display)) else $error("outputs moved");
    a_step_up_limit: assert property (freq_valid && run_age_q > 2 * TICK_CYCLES
        |-> step_d <= $signed({3'b000, max_step_up})) else $error("output rose too far");
    a_step_down_limit: assert property (freq_valid && run_age_q > 2 * TICK_CYCLES
        |-> -step_d <= $signed({3'b000, max_step_down})) else $error("output fell too far");
    a_reverse_cap: assert property (freq_valid |-> freq_reference >= -$signed({2'b00, rev_lim}))
        else $error("reverse cap broken");
    a_freq_scale: assert property (freq_valid && output_filter_time == 13'h0000
        && !regulator_output[17] |-> {16'h0000, freq_reference} == freq_exp)
        else $error("freq scaling wrong");
    a_display_scale: assert property (freq_valid && setting_source_select == SP_DIGITAL
        && setpoint_ramp_time == 16'h0000 && digital_setpoint <= 16'h2710 && age_q > TICK_CYCLES
        |-> {18'h00000, setpoint_display} == disp_exp) else $error("setpoint display scaling");
    a_start_hold: assert property (s_hold_update
        |-> regulator_output == $signed({2'b00, start_output_value}))
        else $error("hold value wrong");
endmodule // ppr_regulator_asserts
bind ppr_regulator ppr_regulator_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_asserts (.*);
`default_nettype wire

// >>> verification/ppr_src_model.sv
// far side: analog, pulse and comm channels, and the drive taking the reference
`timescale 1ns/1ps
`default_nettype none
module ppr_src_model (
    // clock
    input wire logic clk,
    // requested channel levels, 0.01 % units
    input wire logic signed [15:0] lvl_a1,
    input wire logic signed [15:0] lvl_a2,
    input wire logic signed [15:0] lvl_a3,
    input wire logic [15:0] lvl_pu,
    input wire logic signed [15:0] lvl_cm,
    // channels seen by the regulator
    output wire logic signed [15:0] analog_input_one,
    output wire logic signed [15:0] analog_input_two,
    output wire logic signed [15:0] analog_input_three,
    output wire logic [15:0] pulse_input,
    output wire logic signed [15:0] comm_value,
    // frequency path
    input wire logic freq_valid,
    output var int upd_cnt = 0
);
    assign analog_input_one = lvl_a1;
    assign analog_input_two = lvl_a2;
    assign analog_input_three = lvl_a3;
    assign pulse_input = lvl_pu;
    assign comm_value = lvl_cm;
    // drive takes the reference on the strobe
    always @(posedge clk) begin
        if (freq_valid === 1'b1)
            upd_cnt <= upd_cnt + 1;
    end
endmodule // ppr_src_model
`default_nettype wire

// >>> verification/tb_process_pid_regulator.sv
// self-checking bench of the process pid regulator
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
    $display("ERROR %0t got %0h exp %0h", $time, (a), (e)); end end
module tb_process_pid_regulator;
    import ppr_pkg::*;
    localparam int SP_EXP[9] = '{300, 600, 200, 400, 800, 1000, 300, 300, 300};
    localparam int FB_EXP[9] = '{600, 200, 400, 400, 800, 1000, 800, 600, 200};
    int num_errors = 0, checks_done = 0, cyc = 0, upd_cnt;
    logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, action_direction = 1'b0, freq_valid;
    logic [1:0] digital_input_terminal = 2'b00;
    logic signed [15:0] lvl_a1 = 16'sh0bb8, lvl_a2 = 16'sh03e8, lvl_a3 = 16'sh07d0;
    logic signed [15:0] lvl_cm = 16'sh1388;
    logic signed [15:0] analog_input_one, analog_input_two, analog_input_three, comm_value;
    logic [15:0] lvl_pu = 16'h0fa0, pulse_input, setpoint_display, feedback_display;
    logic [15:0] digital_setpoint = 16'h05dc, display_full_scale = 16'h07d0;
    logic [15:0] switch_threshold_low = 16'h07d0, switch_threshold_high = 16'h1f40;
    logic [15:0] start_output_value = 16'h09c4, start_hold_time = 16'h0001;
    logic [15:0] max_step_up = 16'h0064, max_step_down = 16'h012c, reverse_freq_cap = 16'h00c8;
    logic [15:0] max_frequency = 16'h1388, deviation_deadband = '0, diff_term_clamp = 16'h000a;
    logic [15:0] setpoint_ramp_time = '0;
    logic [12:0] feedback_filter_time = '0, output_filter_time = '0;
    logic [9:0] prop_gain_set_one = 10'h3e8, integral_time_set_one = 10'h3e8;
    logic [9:0] prop_gain_set_two = '0, integral_time_set_two = 10'h3e8;
    logic [13:0] diff_time_set_one = '0, diff_time_set_two = '0;
    ppr_gsw_e gain_switch_condition = GSW_NONE;
    ppr_sp_src_e setting_source_select = SP_DIGITAL;
    ppr_fb_src_e feedback_source_select = FB_AIN1;
    logic signed [17:0] freq_reference;
    ppr_pct_t regulator_output, prev;
    ppr_src_model i_src (.*);
    ppr_regulator #(.TICK_CYCLES(300)) i_dut (.*);
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ~43 updates of 300 cycles; ceiling leaves margin
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            complete_run;
        end
    end
    // wait for n more updates taken by the drive
    task automatic upd(input int n);
        int n0;
        n0 = upd_cnt;
        while (upd_cnt < n0 + n)
            @(negedge clk);
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        // setting codes 6 and 7 fall back to digital; k of 8 wraps to code 0
        for (int k = 0; k < 9; k++) begin
            setting_source_select = ppr_sp_src_e'(k[2:0]);
            feedback_source_select = ppr_fb_src_e'(k[3:0]);
            upd(1);
            `CHK(setpoint_display, SP_EXP[k])
            `CHK(feedback_display, FB_EXP[k])
        end
        setting_source_select = SP_DIGITAL;
        feedback_source_select = FB_AIN2;
        run = 1'b1;
        upd(1);
        `CHK(regulator_output, 2500)
        `CHK(freq_reference, 1250)
        upd(4);
        `CHK(regulator_output, 2500)
        upd(1);
        `CHK(regulator_output, 2200)
        digital_setpoint = 16'h2328;
        upd(1);
        `CHK(regulator_output, 2300)
        action_direction = 1'b1;
        upd(1);
        `CHK(regulator_output, 2000)
        digital_input_terminal = 2'b10;
        upd(1);
        `CHK(regulator_output, 2100)
        digital_input_terminal = 2'b00;
        upd(9);
        `CHK(regulator_output, -600)
        `CHK(freq_reference, -200)
        deviation_deadband = 16'h2710;
        upd(2);
        `CHK(regulator_output, -600)
        deviation_deadband = '0;
        action_direction = 1'b0;
        prop_gain_set_one = '0;
        prop_gain_set_two = 10'h3e8;
        gain_switch_condition = GSW_TERMINAL;
        upd(8);
        `CHK(regulator_output < 100, 1'b1)
        digital_input_terminal = 2'b01;
        prev = regulator_output;
        upd(1);
        `CHK(regulator_output, prev + 100)
        gain_switch_condition = GSW_AUTO;
        digital_input_terminal = 2'b00;
        lvl_a2 = 16'sh01f4;
        upd(2);
        prev = regulator_output;
        upd(1);
        `CHK(regulator_output, prev + 100)
        gain_switch_condition = GSW_NONE;
        prev = regulator_output;
        upd(1);
        `CHK(regulator_output < prev, 1'b1)
        complete_run;
    end
endmodule // tb_process_pid_regulator
`default_nettype wire
